/* verilog/ebw_pkg.sv */
// shared constants, register map and types for the external bus wait and arbitration block
package ebw_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses on the wishbone slave)
    // ------------------------------------------------------------------
    localparam int          ADR_W         = 8;
    localparam int          DAT_W         = 32;
    localparam logic [7:0]  WSC_ADDR      = 8'h00;
    localparam logic [7:0]  OMR_ADDR      = 8'h04;
    localparam logic [7:0]  STAT_ADDR     = 8'h08;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          WS_CNT_W      = 5;
    localparam int          WSC_CNT_LSB   = 0;
    localparam int          WSC_HOLD_BIT  = 8;
    localparam int          OMR_TAS_BIT   = 0;
    localparam int          OMR_ABE_BIT   = 1;
    localparam int          ST_MASTER_BIT = 0;
    localparam int          ST_CYCLE_BIT  = 1;
    localparam int          ST_REQ_BIT    = 2;
    localparam int          ST_BBDRV_BIT  = 3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [4:0]  WS_CNT_RST    = 5'h01;
    localparam logic        HOLD_RST      = 1'b0;
    localparam logic        TAS_RST       = 1'b0;
    localparam logic        ABE_RST       = 1'b0;
    localparam logic [4:0]  WS_CNT_ZERO   = 5'h00;
    localparam logic [4:0]  WS_CNT_ONE    = 5'h01;
    localparam logic [2:0]  SYNC_RST      = 3'h7;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       hold;
        logic [4:0] cnt;
    } ebw_wsc_s;

    typedef struct packed {
        logic abe;
        logic ack_sync_select;
    } ebw_omr_s;

    typedef enum logic [3:0] {
        ST_SLAVE   = 4'h1,
        ST_WAIT_BB = 4'h2,
        ST_MASTER  = 4'h4,
        ST_RELEASE = 4'h8
    } ebw_arb_e;

endpackage

/* verilog/ebw_sync.sv */
// two-flop synchroniser for the asynchronous bus inputs
`timescale 1ns/1ps
module ebw_sync (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] d,
    output logic      [2:0] q
);

    logic [2:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= ebw_pkg::SYNC_RST;
            q      <= ebw_pkg::SYNC_RST;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

/* verilog/ebw_wait.sv */
// wait-state counter that closes an external bus cycle
`timescale 1ns/1ps
module ebw_wait (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic [4:0] ws_cnt,
    input  wire logic       ack,
    output logic            active,
    output logic            done,
    output logic            cnt_zero,
    output logic            ack_seen
);

    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic       zero_ws_r;
    logic       ack_lat_r;
    logic       end_now;
    logic       active_nxt;

    assign cnt_zero   = (cnt_r == ebw_pkg::WS_CNT_ZERO);
    assign ack_seen   = ack_lat_r | ack;
    // cycle closes when programmed waits are spent and ack has been seen, or without ack when zero waits were programmed
    assign end_now    = active & cnt_zero & (zero_ws_r | ack_seen);
    assign active_nxt = start | (active & ~end_now);
    assign cnt_nxt    = start ? ws_cnt :
                        (active & ~cnt_zero) ? cnt_r - ebw_pkg::WS_CNT_ONE : cnt_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r     <= ebw_pkg::WS_CNT_ZERO;
            zero_ws_r <= 1'b0;
            ack_lat_r <= 1'b0;
            active    <= 1'b0;
            done      <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            zero_ws_r <= start ? (ws_cnt == ebw_pkg::WS_CNT_ZERO) : zero_ws_r;
            // ack outside an active cycle is dropped
            ack_lat_r <= ~start & active & ~end_now & ack_seen;
            active    <= active_nxt;
            done      <= end_now;
        end
    end

endmodule

/* verilog/ebw_top.sv */
// external bus wait-state extension and bus arbitration requester
//
// Overview of operation
// - ack ignored unless owning bus and cycling
// - missing ack stretches cycle without limit unless wait count is zero
// - cycle ends one clock after synced ack
// - wait count is max of config, ack
// - mode bit picks sync or async ack
// - request always driven, low when bus needed
// - request independent of master or slave state
// - hold bit forces request asserted
// - only external accesses or the hold bit raise request
// - reset deasserts request, returns to slave
// - after grant wait busy high, then master
// - grant removed: release after current cycle
// - take bus and busy only after busy high
// - master may park bus holding busy low
// - busy released by driving high then floating
`timescale 1ns/1ps
module ebw_top (
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        ACC_REQ,
    input  wire logic        ACC_EXT,
    output logic             ACC_DONE,
    output logic             BUS_CYCLE,
    output logic             BUS_MASTER,
    input  wire logic        XFER_ACKNOWLEDGE_N,
    output logic             BUS_REQUEST_N,
    input  wire logic        BUS_GRANT_N,
    input  wire logic        BUS_BUSY_N_I,
    output logic             BUS_BUSY_N_O,
    output logic             BUS_BUSY_N_OE
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    ebw_pkg::ebw_wsc_s wait_state_config_r;
    ebw_pkg::ebw_omr_s operating_mode_reg_r;
    ebw_pkg::ebw_arb_e state_r;
    ebw_pkg::ebw_arb_e state_nxt;
    logic [2:0]        sync_in;
    logic [2:0]        sync_q;
    logic [2:0]        raw_r;
    logic              ack_n_sel;
    logic              grant_n_sel;
    logic              busy_n_sel;
    logic              ack_now;
    logic              granted;
    logic              busy_free;
    logic              need;
    logic              req_nxt;
    logic              cyc_start;
    logic              cyc_active;
    logic              cyc_done;
    logic              cnt_zero;
    logic              ack_seen;
    logic              wb_req;
    logic              wb_wr;
    logic              sel_wsc;
    logic              sel_omr;
    logic              sel_stat;
    logic [31:0]       rd_data;
    logic [31:0]       stat_word;
    logic              master_nxt;
    logic              bb_oe_nxt;

    // ------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------
    assign wb_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wb_wr    = wb_req & WB_WE_I;
    assign sel_wsc  = (WB_ADR_I == ebw_pkg::WSC_ADDR);
    assign sel_omr  = (WB_ADR_I == ebw_pkg::OMR_ADDR);
    assign sel_stat = (WB_ADR_I == ebw_pkg::STAT_ADDR);

    assign stat_word = {28'h0000000, BUS_BUSY_N_OE & ~BUS_BUSY_N_O, ~BUS_REQUEST_N,
                        cyc_active, BUS_MASTER};
    assign rd_data   = sel_wsc  ? {23'h000000, wait_state_config_r.hold, 3'h0,
                                   wait_state_config_r.cnt} :
                       sel_omr  ? {30'h00000000, operating_mode_reg_r} :
                       sel_stat ? stat_word : 32'h00000000;

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else begin
            WB_ACK_O <= wb_req;
            WB_DAT_O <= wb_req ? rd_data : 32'h00000000;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            wait_state_config_r.cnt  <= ebw_pkg::WS_CNT_RST;
            wait_state_config_r.hold <= ebw_pkg::HOLD_RST;
            operating_mode_reg_r.ack_sync_select <= ebw_pkg::TAS_RST;
            operating_mode_reg_r.abe <= ebw_pkg::ABE_RST;
        end else begin
            if (wb_wr && sel_wsc && WB_SEL_I[0]) begin
                wait_state_config_r.cnt <= WB_DAT_I[ebw_pkg::WSC_CNT_LSB +: ebw_pkg::WS_CNT_W];
            end
            if (wb_wr && sel_wsc && WB_SEL_I[1]) begin
                wait_state_config_r.hold <= WB_DAT_I[ebw_pkg::WSC_HOLD_BIT];
            end
            if (wb_wr && sel_omr && WB_SEL_I[0]) begin
                operating_mode_reg_r.ack_sync_select <= WB_DAT_I[ebw_pkg::OMR_TAS_BIT];
                operating_mode_reg_r.abe <= WB_DAT_I[ebw_pkg::OMR_ABE_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // input sampling: one flop for synchronous use, two for asynchronous
    // ------------------------------------------------------------------
    assign sync_in = {BUS_BUSY_N_I, BUS_GRANT_N, XFER_ACKNOWLEDGE_N};

    ebw_sync i_ebw_sync (
        .clk   (MCLK),
        .rst_n (RSTN),
        .d     (sync_in),
        .q     (sync_q)
    );

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            raw_r <= ebw_pkg::SYNC_RST;
        end else begin
            raw_r <= sync_in;
        end
    end

    assign ack_n_sel   = operating_mode_reg_r.ack_sync_select ? raw_r[0] : sync_q[0];
    assign grant_n_sel = operating_mode_reg_r.abe ? sync_q[1] : raw_r[1];
    assign busy_n_sel  = operating_mode_reg_r.abe ? sync_q[2] : raw_r[2];
    assign ack_now     = ~ack_n_sel & cyc_active & BUS_MASTER;
    assign granted     = ~grant_n_sel;
    assign busy_free   = busy_n_sel;

    // ------------------------------------------------------------------
    // bus request
    // ------------------------------------------------------------------
    assign need    = ACC_REQ & ACC_EXT;
    assign req_nxt = need | wait_state_config_r.hold;

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            BUS_REQUEST_N <= 1'b1;
        end else begin
            BUS_REQUEST_N <= ~req_nxt;
        end
    end

    // ------------------------------------------------------------------
    // arbitration state machine
    // ------------------------------------------------------------------
    assign cyc_start = (state_r == ebw_pkg::ST_MASTER) & need & granted
                       & ~cyc_active & ~ACC_DONE;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ebw_pkg::ST_SLAVE: begin
                if (granted) begin
                    state_nxt = ebw_pkg::ST_WAIT_BB;
                end
            end
            ebw_pkg::ST_WAIT_BB: begin
                if (!granted) begin
                    state_nxt = ebw_pkg::ST_SLAVE;
                end else if (busy_free) begin
                    state_nxt = ebw_pkg::ST_MASTER;
                end
            end
            ebw_pkg::ST_MASTER: begin
                // parked while granted; leave only between cycles
                if (!granted && !cyc_active) begin
                    state_nxt = ebw_pkg::ST_RELEASE;
                end
            end
            ebw_pkg::ST_RELEASE: begin
                state_nxt = ebw_pkg::ST_SLAVE;
            end
            default: begin
                state_nxt = ebw_pkg::ST_SLAVE;
            end
        endcase
    end

    assign master_nxt = (state_nxt == ebw_pkg::ST_MASTER);
    assign bb_oe_nxt  = master_nxt | (state_nxt == ebw_pkg::ST_RELEASE);

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r       <= ebw_pkg::ST_SLAVE;
            BUS_MASTER    <= 1'b0;
            BUS_BUSY_N_O  <= 1'b1;
            BUS_BUSY_N_OE <= 1'b0;
        end else begin
            state_r       <= state_nxt;
            BUS_MASTER    <= master_nxt;
            BUS_BUSY_N_O  <= ~master_nxt;
            BUS_BUSY_N_OE <= bb_oe_nxt;
        end
    end

    // ------------------------------------------------------------------
    // external cycle timing
    // ------------------------------------------------------------------
    ebw_wait i_ebw_wait (
        .clk      (MCLK),
        .rst_n    (RSTN),
        .start    (cyc_start),
        .ws_cnt   (wait_state_config_r.cnt),
        .ack      (ack_now),
        .active   (cyc_active),
        .done     (cyc_done),
        .cnt_zero (cnt_zero),
        .ack_seen (ack_seen)
    );

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            BUS_CYCLE <= 1'b0;
        end else begin
            BUS_CYCLE <= cyc_start | (cyc_active & ~(cnt_zero & ack_seen));
        end
    end

    assign ACC_DONE = cyc_done;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_release;
        BUS_BUSY_N_OE && BUS_BUSY_N_O ##1 !BUS_BUSY_N_OE;
    endsequence

    sequence s_leave_master;
        state_r == ebw_pkg::ST_MASTER ##1 state_r == ebw_pkg::ST_RELEASE;
    endsequence

    req_follows_need_a: assert property (@(posedge MCLK) disable iff (!RSTN)
        (need || wait_state_config_r.hold) |=> !BUS_REQUEST_N)
        else $error("bus request not asserted while needed");

    internal_no_req_a: assert property (@(posedge MCLK) disable iff (!RSTN)
        (!need && !wait_state_config_r.hold) |=> BUS_REQUEST_N)
        else $error("bus request asserted without external need");

    ack_ignored_a: assert property (@(posedge MCLK) disable iff (!RSTN)
        !cyc_active |=> !cyc_done)
        else $error("cycle ended outside an active cycle");

    ack_end_timing_a: assert property (@(posedge MCLK) disable iff (!RSTN)
        (cyc_active && cnt_zero && ack_now) |=> cyc_done)
        else $error("cycle did not end one clock after ack");

    stretch_no_ack_a: assert property (@(posedge MCLK) disable iff (!RSTN)
        (cyc_active && !ack_seen && !i_ebw_wait.zero_ws_r) |=> (!cyc_done && cyc_active))
        else $error("cycle ended without ack");

    min_waits_a: assert property (@(posedge MCLK) disable iff (!RSTN)
        (cyc_active && !cnt_zero) |=> !cyc_done)
        else $error("cycle shorter than programmed waits");

    grant_wait_busy_a: assert property (@(posedge MCLK) disable iff (!RSTN)
        (state_r == ebw_pkg::ST_WAIT_BB && !busy_free) |=> !BUS_MASTER)
        else $error("mastership taken while bus busy");

    take_after_free_a: assert property (@(posedge MCLK) disable iff (!RSTN)
        $rose(BUS_MASTER) |-> ($past(busy_free) && !BUS_BUSY_N_O && BUS_BUSY_N_OE))
        else $error("busy driven before bus was free");

    grant_loss_a: assert property (@(posedge MCLK) disable iff (!RSTN)
        (BUS_MASTER && !granted && !cyc_active) |=> !BUS_MASTER)
        else $error("mastership kept after grant removal");

    parked_bus_a: assert property (@(posedge MCLK) disable iff (!RSTN)
        (BUS_MASTER && granted) |=> BUS_MASTER)
        else $error("parked bus dropped while granted");

    busy_release_a: assert property (@(posedge MCLK) disable iff (!RSTN)
        s_leave_master |-> s_release)
        else $error("busy not driven high then released");

endmodule

/* verif/ebw_far.sv */
// arbiter, acknowledging device and busy line pull-up facing the block
`timescale 1ns/1ps
module ebw_far (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       bus_cycle,
    input  wire logic       busy_n_o,
    input  wire logic       busy_n_oe,
    input  wire logic       grant_en,
    input  wire logic       other_busy,
    input  wire logic [3:0] ack_dly,
    output logic            ack_n,
    output logic            grant_n,
    output logic            busy_n_i
);
    logic [3:0] cnt_r;

    // -------------------------------------------------------------
    // busy wire: pull-up unless a master drives it low
    // -------------------------------------------------------------
    assign busy_n_i = (busy_n_oe ? busy_n_o : 1'b1) & ~other_busy;

    // -------------------------------------------------------------
    // grant and acknowledge
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r   <= 4'h0;
            ack_n   <= 1'b1;
            grant_n <= 1'b1;
        end else begin
            grant_n <= ~grant_en;
            if (!bus_cycle) begin
                cnt_r <= 4'h0;
                ack_n <= 1'b1;
            end else begin
                if (cnt_r != 4'hF) begin
                    cnt_r <= cnt_r + 4'h1;
                end
                // plain static device: ack held off until ack_dly clocks into the cycle
                ack_n <= (cnt_r < ack_dly);
            end
        end
    end
endmodule

/* verif/test_ebw_top.sv */
// self-checking bench for the external bus wait and arbitration block
`timescale 1ns/1ps
module test_ebw_top;
    logic        mclk, rstn, cyc, stb, we, acc_req, acc_ext, grant_en, other_busy;
    logic [7:0]  adr;
    logic [3:0]  sel, ack_dly;
    logic [31:0] dat_i, dat_o, rd;
    logic        ack, acc_done, bus_cycle, bus_master, xack_n, breq_n, bgnt_n;
    logic        bb_i, bb_o, bb_oe;
    int          failures, num_checks;

    ebw_top i_ebw_top (.MCLK(mclk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .ACC_REQ(acc_req), .ACC_EXT(acc_ext), .ACC_DONE(acc_done),
        .BUS_CYCLE(bus_cycle), .BUS_MASTER(bus_master), .XFER_ACKNOWLEDGE_N(xack_n),
        .BUS_REQUEST_N(breq_n), .BUS_GRANT_N(bgnt_n), .BUS_BUSY_N_I(bb_i),
        .BUS_BUSY_N_O(bb_o), .BUS_BUSY_N_OE(bb_oe));

    ebw_far i_ebw_far (.clk(mclk), .rst_n(rstn), .bus_cycle(bus_cycle), .busy_n_o(bb_o),
        .busy_n_oe(bb_oe), .grant_en(grant_en), .other_busy(other_busy), .ack_dly(ack_dly),
        .ack_n(xack_n), .grant_n(bgnt_n), .busy_n_i(bb_i));

    // -------------------------------------------------------------
    // shared tasks
    // -------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_sig(input int which, input logic val);
        logic s;
        for (int i = 0; i < 300; i++) begin
            @(posedge mclk);
            #1;
            case (which)
                0: s = bus_master;
                1: s = acc_done;
                2: s = ack;
                default: s = bus_cycle;
            endcase
            if (s === val) begin
                return;
            end
        end
        failures++;
        close_out();
    endtask

    // one classic cycle: hold until ack is sampled at an edge, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_i <= d;
        sel   <= 4'hF;
        wait_sig(2, 1'b1);
        rd = dat_o;
        @(posedge mclk);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_regs();
        wb(1'b0, ebw_pkg::WSC_ADDR, 32'h0);
        check(rd, {27'h0, ebw_pkg::WS_CNT_RST});
        wb(1'b0, ebw_pkg::OMR_ADDR, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, 8'h0C, 32'hFFFFFFFF);
        wb(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h0);
    endtask

    task automatic t_request();
        @(posedge mclk);
        acc_req <= 1'b1;
        acc_ext <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        check(breq_n, 1'b1);
        @(posedge mclk);
        acc_req <= 1'b0;
        wb(1'b1, ebw_pkg::WSC_ADDR, 32'h00000101);
        repeat (2) @(posedge mclk);
        #1;
        check(breq_n, 1'b0);
        wb(1'b1, ebw_pkg::WSC_ADDR, 32'h00000001);
        repeat (2) @(posedge mclk);
        #1;
        check(breq_n, 1'b1);
    endtask

    task automatic t_busy();
        wb(1'b1, ebw_pkg::OMR_ADDR, 32'h00000002);
        @(posedge mclk);
        other_busy <= 1'b1;
        grant_en   <= 1'b1;
        repeat (10) @(posedge mclk);
        #1;
        check({bus_master, bb_oe}, 2'h0);
        @(posedge mclk);
        other_busy <= 1'b0;
        wait_sig(0, 1'b1);
        check({bb_o, bb_oe}, 2'h1);
        wb(1'b0, ebw_pkg::STAT_ADDR, 32'h0);
        check(rd, 32'h00000009);
    endtask

    task automatic t_access(input logic ack_sync_select, input logic [4:0] n, input logic [3:0] d);
        int c;
        int lo;
        lo = (n > d) ? n : d;
        wb(1'b1, ebw_pkg::OMR_ADDR, {30'h0, 1'b1, ack_sync_select});
        wb(1'b1, ebw_pkg::WSC_ADDR, {27'h0, n});
        ack_dly <= d;
        @(posedge mclk);
        acc_req <= 1'b1;
        acc_ext <= 1'b1;
        wait_sig(3, 1'b1);
        check(breq_n, 1'b0);
        c = 0;
        while (acc_done !== 1'b1 && c < 300) begin
            @(posedge mclk);
            #1;
            c++;
        end
        @(posedge mclk);
        acc_req <= 1'b0;
        check(c >= lo && c <= lo + 6, 1'b1);
        repeat (3) @(posedge mclk);
    endtask

    task automatic t_park();
        logic rel;
        rel = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        check({breq_n, bus_master, bb_o}, 3'h6);
        @(posedge mclk);
        grant_en <= 1'b0;
        for (int i = 0; i < 20 && bb_oe !== 1'b0; i++) begin
            @(posedge mclk);
            #1;
            rel = rel | (bb_oe === 1'b1 && bb_o === 1'b1);
        end
        check({rel, bb_oe, bb_i, bus_master}, 4'hA);
    endtask

    task automatic t_reset_mid();
        wb(1'b1, ebw_pkg::WSC_ADDR, 32'h00000101);
        @(posedge mclk);
        grant_en <= 1'b1;
        wait_sig(0, 1'b1);
        @(posedge mclk);
        rstn <= 1'b0;
        #2;
        check({breq_n, bus_master, bb_oe}, 3'h4);
        @(posedge mclk);
        rstn <= 1'b1;
        wb(1'b0, ebw_pkg::WSC_ADDR, 32'h0);
        check(rd, {27'h0, ebw_pkg::WS_CNT_RST});
        check(breq_n, 1'b1);
        wait_sig(0, 1'b1);
        check({bb_o, bb_oe}, 2'h1);
    endtask

    // -------------------------------------------------------------
    // clock, reset and main sequence
    // -------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    initial begin
        rstn = 1'b0;
        {cyc, stb, we, acc_req, acc_ext, grant_en, other_busy} = 7'h00;
        adr = 8'h00;
        sel = 4'h0;
        dat_i = 32'h0;
        ack_dly = 4'h0;
        failures = 0;
        num_checks = 0;
        repeat (11) @(posedge mclk);
        #1;
        check({breq_n, bus_master, bb_oe}, 3'h4);
        @(posedge mclk);
        rstn <= 1'b1;
        t_regs();
        t_request();
        t_busy();
        t_access(1'b1, 5'h08, 4'h0);
        t_access(1'b0, 5'h01, 4'hC);
        t_access(1'b1, 5'h01, 4'h9);
        t_park();
        t_reset_mid();
        close_out();
    end
endmodule
